// ===== hw/synth_cfg_defines.svh
/*
  register offsets, field positions, reset values and ratio codes of the clock synthesizer
  configuration bank.
  assumes: included by bare name from the design files and the bench; the package does not include it.
*/
`ifndef SYNTH_CFG_DEFINES_SVH
`define SYNTH_CFG_DEFINES_SVH

// ==========================================================
// register offsets
`define OFS_REF_OUTPUT_CONTROL       8'h3C
`define OFS_SYNTH_FEEDBACK_DIV_PV    8'h3D
`define OFS_SYNTH_FEEDBACK_DIV_N     8'h3E
`define OFS_OSCILLATOR_BIAS_CONTROL  8'h3F
`define OFS_LANE_PREEMPHASIS_CONTROL 8'h48

// ==========================================================
// field positions
`define POS_REF_OUT_ENABLE 0
`define POS_DIV_FIRST_LO   0
`define POS_DIV_SECOND_LO  2
`define POS_DIV_THIRD_LO   0
`define POS_BIAS_LO        0
`define POS_PREEMPH_LO     0

// ==========================================================
// reset values
`define RST_REF_OUTPUT_CONTROL       8'h01
`define RST_SYNTH_FEEDBACK_DIV_PV    8'h00
`define RST_SYNTH_FEEDBACK_DIV_N     8'h20
`define RST_OSCILLATOR_BIAS_CONTROL  8'h4F
`define RST_LANE_PREEMPHASIS_CONTROL 8'h00

// ==========================================================
// writable masks (reserved bits held at zero)
`define MASK_REF_OUTPUT_CONTROL       8'h01
`define MASK_SYNTH_FEEDBACK_DIV_PV    8'h0F
`define MASK_SYNTH_FEEDBACK_DIV_N     8'h3F
`define MASK_OSCILLATOR_BIAS_CONTROL  8'h7F
`define MASK_LANE_PREEMPHASIS_CONTROL 8'h0F

// ==========================================================
// divide ratios
`define RATIO_FIRST_CODE0  3'h5
`define RATIO_FIRST_CODE1  3'h4
`define RATIO_FIRST_CODE2  3'h3
`define RATIO_SECOND_CODE0 3'h1
`define RATIO_SECOND_CODE1 3'h2
`define RATIO_SECOND_CODE2 3'h4

`endif

// ===== hw/synth_cfg_pkg.sv
/*
  types of the clock synthesizer configuration bank.
  assumes: nothing beyond the defines header.
*/
package synth_cfg_pkg;

  // ==========================================================
  // register request port, write and read
  typedef struct packed {
    logic       write_strobe;
    logic       read_strobe;
    logic [7:0] address;
    logic [7:0] write_data;
  } reg_request_t;

  // ==========================================================
  // configuration handed to the synthesizer
  typedef struct packed {
    logic       ref_out_enable;
    logic [1:0] first_div_code;
    logic [1:0] second_div_code;
    logic [5:0] third_div_ratio;
    logic [6:0] oscillator_bias_level;
    logic [3:0] lane_preemphasis;
  } synth_config_t;

  // ==========================================================
  // divider counter states
  typedef enum logic [1:0] {
    DIV_IDLE    = 2'b00,
    DIV_RUNNING = 2'b01
  } div_state_t;

  typedef struct packed {
    div_state_t state;
    logic [5:0] count;
    logic       tick;
  } div_regs_t;

endpackage

// ===== hw/ratio_divider.sv
/*
  programmable divider: one tick every ratio input pulses.
  assumes: ratio changed only while the synthesizer is in reset.
*/
`timescale 1ns/100ps
`include "synth_cfg_defines.svh"

module ratio_divider #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // control
  input  wire logic             hold,
  input  wire logic [WIDTH-1:0] ratio,
  input  wire logic             in_pulse,
  // output
  output logic                  out_pulse
);

  synth_cfg_pkg::div_regs_t r;
  synth_cfg_pkg::div_regs_t next_r;

  // ==========================================================
  // count input pulses
  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    case (r.state)
      synth_cfg_pkg::DIV_IDLE: begin
        next_r.count = '0;
        if (!hold && ratio != '0) begin
          next_r.state = synth_cfg_pkg::DIV_RUNNING;
        end
      end
      synth_cfg_pkg::DIV_RUNNING: begin
        if (hold || ratio == '0) begin
          next_r.state = synth_cfg_pkg::DIV_IDLE;
          next_r.count = '0;
        end else if (in_pulse) begin
          if (r.count + 6'h01 >= 6'(ratio)) begin
            next_r.count = '0;
            next_r.tick  = 1'b1;
          end else begin
            next_r.count = r.count + 6'h01;
          end
        end
      end
      default: begin
        next_r.state = synth_cfg_pkg::DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '{state: synth_cfg_pkg::DIV_IDLE, count: 6'h00, tick: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign out_pulse = r.tick;

endmodule

// ===== hw/clock_synth_config_regs.sv
/*
  configuration registers of the clock synthesizer and lane pre-emphasis, with the
  reference output gate and the three-stage feedback divider chain.
  assumes: register requests arrive synchronous to clk from the serial programming port;
  osc_pulse is a one-cycle pulse per oscillator period (model of the oscillator edge).
*/
// How it works
// [RL1] reference output on only when enable bit set and synthesizer enabled
// [RL2] reference output enable bit resets to one
// [RL3] second divider code 0,1,2 divides by 1,2,4; its output is sampling clock
// [RL4] first divider code 0,1,2 divides by 5,4,3; feeds second divider
// [RL5] software sets synthesizer reset bit before changing any divider field
// [RL6] third divider six-bit value is the ratio, 1 to 63, reset 32
// [RL7] third divider divides sampling clock into detector feedback clock
// [RL8] software writes oscillator bias 0x4A, not relying on reset 0x4F
// [RL9] one pre-emphasis field drives all eight lanes together
// [RL10] software writes reserved bits as zero
`timescale 1ns/100ps
`include "synth_cfg_defines.svh"

module clock_synth_config_regs #(
  parameter int LANES = 8
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // register port
  input  wire synth_cfg_pkg::reg_request_t   req,
  output logic [7:0]                         read_data,
  output logic                               read_valid,
  // synthesizer side
  input  wire logic                          synth_enable,
  input  wire logic                          synth_reset_bit,
  input  wire logic                          osc_pulse,
  output logic                               synth_reference_output,
  output logic                               sampling_pulse,
  output logic                               feedback_pulse,
  output synth_cfg_pkg::synth_config_t       config_out,
  output logic [LANES-1:0][3:0]              lane_preemphasis
);

  typedef struct packed {
    logic [7:0] ref_ctrl;
    logic [7:0] div_pv;
    logic [7:0] div_n;
    logic [7:0] bias;
    logic [7:0] preemph;
    logic [7:0] rdata;
    logic       rvalid;
    logic       refo;
  } state_t;

  state_t s;
  state_t next_s;
  logic   first_tick;

  // ==========================================================
  // ratio decode
  function automatic logic [2:0] first_ratio(input logic [1:0] code);
    case (code)
      2'h0:    first_ratio = `RATIO_FIRST_CODE0;
      2'h1:    first_ratio = `RATIO_FIRST_CODE1;
      2'h2:    first_ratio = `RATIO_FIRST_CODE2;
      default: first_ratio = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] second_ratio(input logic [1:0] code);
    case (code)
      2'h0:    second_ratio = `RATIO_SECOND_CODE0;
      2'h1:    second_ratio = `RATIO_SECOND_CODE1;
      2'h2:    second_ratio = `RATIO_SECOND_CODE2;
      default: second_ratio = 3'h0;
    endcase
  endfunction

  // ==========================================================
  // register file
  always_comb begin
    next_s        = s;
    next_s.rvalid = 1'b0;
    if (req.write_strobe) begin
      case (req.address)
        `OFS_REF_OUTPUT_CONTROL:
          next_s.ref_ctrl = req.write_data & `MASK_REF_OUTPUT_CONTROL;
        `OFS_SYNTH_FEEDBACK_DIV_PV:
          next_s.div_pv = req.write_data & `MASK_SYNTH_FEEDBACK_DIV_PV;
        `OFS_SYNTH_FEEDBACK_DIV_N:
          next_s.div_n = req.write_data & `MASK_SYNTH_FEEDBACK_DIV_N;
        `OFS_OSCILLATOR_BIAS_CONTROL:
          next_s.bias = req.write_data & `MASK_OSCILLATOR_BIAS_CONTROL;
        `OFS_LANE_PREEMPHASIS_CONTROL:
          next_s.preemph = req.write_data & `MASK_LANE_PREEMPHASIS_CONTROL;
        default: begin
        end
      endcase
    end
    if (req.read_strobe) begin
      next_s.rvalid = 1'b1;
      case (req.address)
        `OFS_REF_OUTPUT_CONTROL:       next_s.rdata = s.ref_ctrl;
        `OFS_SYNTH_FEEDBACK_DIV_PV:    next_s.rdata = s.div_pv;
        `OFS_SYNTH_FEEDBACK_DIV_N:     next_s.rdata = s.div_n;
        `OFS_OSCILLATOR_BIAS_CONTROL:  next_s.rdata = s.bias;
        `OFS_LANE_PREEMPHASIS_CONTROL: next_s.rdata = s.preemph;
        default:                       next_s.rdata = 8'h00;
      endcase
    end
    // reference output gate
    next_s.refo = s.ref_ctrl[`POS_REF_OUT_ENABLE] & synth_enable; // [RL1]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s.ref_ctrl <= `RST_REF_OUTPUT_CONTROL; // [RL2]
      s.div_pv   <= `RST_SYNTH_FEEDBACK_DIV_PV;
      s.div_n    <= `RST_SYNTH_FEEDBACK_DIV_N; // [RL6]
      s.bias     <= `RST_OSCILLATOR_BIAS_CONTROL;
      s.preemph  <= `RST_LANE_PREEMPHASIS_CONTROL;
      s.rdata    <= 8'h00;
      s.rvalid   <= 1'b0;
      s.refo     <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // configuration outputs
  assign read_data  = s.rdata;
  assign read_valid = s.rvalid;
  assign synth_reference_output = s.refo;
  assign config_out.ref_out_enable        = s.ref_ctrl[`POS_REF_OUT_ENABLE];
  assign config_out.first_div_code        = s.div_pv[`POS_DIV_FIRST_LO +: 2];
  assign config_out.second_div_code       = s.div_pv[`POS_DIV_SECOND_LO +: 2];
  assign config_out.third_div_ratio       = s.div_n[`POS_DIV_THIRD_LO +: 6];
  assign config_out.oscillator_bias_level = s.bias[`POS_BIAS_LO +: 7];
  assign config_out.lane_preemphasis      = s.preemph[`POS_PREEMPH_LO +: 4];

  // one common setting for every lane
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_preemphasis[i] = s.preemph[`POS_PREEMPH_LO +: 4]; // [RL9]
    end
  end

  // ==========================================================
  // feedback divider chain, held while the synthesizer is in reset
  ratio_divider #(.WIDTH(3)) u_first (
    .clk       (clk),
    .reset     (reset),
    .hold      (synth_reset_bit),
    .ratio     (first_ratio(config_out.first_div_code)), // [RL4]
    .in_pulse  (osc_pulse),
    .out_pulse (first_tick)
  );

  ratio_divider #(.WIDTH(3)) u_second (
    .clk       (clk),
    .reset     (reset),
    .hold      (synth_reset_bit),
    .ratio     (second_ratio(config_out.second_div_code)), // [RL3]
    .in_pulse  (first_tick),
    .out_pulse (sampling_pulse)
  );

  ratio_divider #(.WIDTH(6)) u_third (
    .clk       (clk),
    .reset     (reset),
    .hold      (synth_reset_bit),
    .ratio     (config_out.third_div_ratio), // [RL6]
    .in_pulse  (sampling_pulse),
    .out_pulse (feedback_pulse) // [RL7]
  );

  // ==========================================================
  // checks
  property p_refo_gate;
    @(posedge clk) disable iff (reset)
      !$past(reset) |-> synth_reference_output == $past(s.ref_ctrl[0] & synth_enable);
  endproperty
  a_refo_gate: assert property (p_refo_gate) else $error("reference output gate wrong"); // [RL1]

  property p_refo_reset;
    @(posedge clk) $fell(reset) |-> s.ref_ctrl[0];
  endproperty
  a_refo_reset: assert property (p_refo_reset) else $error("enable bit not one after reset"); // [RL2]

  property p_second_code;
    @(posedge clk) disable iff (reset)
      second_ratio(config_out.second_div_code) ==
        ((config_out.second_div_code == 2'h0) ? 3'h1 :
         (config_out.second_div_code == 2'h1) ? 3'h2 :
         (config_out.second_div_code == 2'h2) ? 3'h4 : 3'h0);
  endproperty
  a_second_code: assert property (p_second_code) else $error("second ratio decode wrong"); // [RL3]

  property p_first_code;
    @(posedge clk) disable iff (reset)
      (config_out.first_div_code == 2'h0) |-> first_ratio(config_out.first_div_code) == 3'h5;
  endproperty
  a_first_code: assert property (p_first_code) else $error("first ratio default not five"); // [RL4]

  property p_hold_quiet;
    @(posedge clk) disable iff (reset)
      synth_reset_bit [*3] |-> !sampling_pulse && !feedback_pulse;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("divider ran in reset"); // [RL5]

  property p_third_reset;
    @(posedge clk) $fell(reset) |-> s.div_n == 8'h20;
  endproperty
  a_third_reset: assert property (p_third_reset) else $error("third ratio reset not 32"); // [RL6]

  property p_feedback_from_sampling;
    @(posedge clk) disable iff (reset)
      feedback_pulse |-> $past(sampling_pulse);
  endproperty
  a_feedback_from_sampling: assert property (p_feedback_from_sampling)
    else $error("feedback without sampling edge"); // [RL7]

  property p_bias_write;
    @(posedge clk) disable iff (reset)
      req.write_strobe && req.address == 8'h3F |=> s.bias == ($past(req.write_data) & 8'h7F);
  endproperty
  a_bias_write: assert property (p_bias_write) else $error("bias write lost"); // [RL8]

  property p_lanes_common;
    @(posedge clk) disable iff (reset)
      lane_preemphasis[LANES-1] == s.preemph[3:0] && lane_preemphasis[0] == s.preemph[3:0];
  endproperty
  a_lanes_common: assert property (p_lanes_common) else $error("lanes differ"); // [RL9]

  property p_reserved_zero;
    @(posedge clk) disable iff (reset)
      s.ref_ctrl[7:1] == 7'h00 && s.div_pv[7:4] == 4'h0 && s.preemph[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RL10]

endmodule

// ===== verif/clock_synth_config_regs_test.sv
/*
  self-checking bench of the clock synthesizer configuration bank: reset values, masking of
  reserved bits, unmapped places, reference output gating, lane fan-out and divider ratios.
  assumes: design files and the defines header are on the include path; one 250 MHz clock.
*/
`timescale 1ns/100ps
`include "synth_cfg_defines.svh"

module clock_synth_config_regs_test;
  // ==========================================================
  // signals
  logic                         clk;
  logic                         reset;
  synth_cfg_pkg::reg_request_t  req;
  logic                         synth_enable;
  logic                         synth_reset_bit;
  logic                         osc_pulse;
  logic [7:0]                   read_data;
  logic                         read_valid;
  logic                         synth_reference_output;
  logic                         sampling_pulse;
  logic                         feedback_pulse;
  synth_cfg_pkg::synth_config_t config_out;
  logic [7:0][3:0]              lane_preemphasis;
  int                           err_count;
  int                           check_count;
  int                           cycle_count;
  logic [7:0]                   reg_addr [5];
  logic [7:0]                   reg_rst [5];
  logic [7:0]                   reg_mask [5];
  logic [7:0]                   rd;
  int                           sp_gap;
  int                           fb_gap;

  clock_synth_config_regs #(
    .LANES(8)
  ) i_dut (
    .clk                    (clk),
    .reset                  (reset),
    .req                    (req),
    .read_data              (read_data),
    .read_valid             (read_valid),
    .synth_enable           (synth_enable),
    .synth_reset_bit        (synth_reset_bit),
    .osc_pulse              (osc_pulse),
    .synth_reference_output (synth_reference_output),
    .sampling_pulse         (sampling_pulse),
    .feedback_pulse         (feedback_pulse),
    .config_out             (config_out),
    .lane_preemphasis       (lane_preemphasis)
  );

  // ==========================================================
  // clock and timeout
  always #2 clk = ~clk;

  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    req.write_strobe = 1'b1;
    req.address = addr;
    req.write_data = data;
    @(negedge clk);
    req.write_strobe = 1'b0;
    @(negedge clk);
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    req.read_strobe = 1'b1;
    req.address = addr;
    @(negedge clk);
    req.read_strobe = 1'b0;
    check({31'h0, read_valid}, 32'h1);
    data = read_data;
    @(negedge clk);
  endtask

  // counts cycles between the last two output pulses; oscillator pulse every other cycle
  task automatic measure(input int cycles, output int sp, output int fb);
    int sp_last;
    int fb_last;
    sp = 0;
    fb = 0;
    sp_last = -1;
    fb_last = -1;
    for (int n = 0; n < cycles; n++) begin
      osc_pulse = (n % 2 == 0);
      @(negedge clk);
      if (sampling_pulse === 1'b1) begin
        if (sp_last >= 0) sp = n - sp_last;
        sp_last = n;
      end
      if (feedback_pulse === 1'b1) begin
        if (fb_last >= 0) fb = n - fb_last;
        fb_last = n;
      end
    end
    osc_pulse = 1'b0;
  endtask

  task automatic run_div(input logic [1:0] c1, input logic [1:0] c2, input logic [5:0] n,
                         input int r1, input int r2, input int cycles);
    synth_reset_bit = 1'b1;
    write_reg(`OFS_SYNTH_FEEDBACK_DIV_PV, {4'h0, c2, c1});
    write_reg(`OFS_SYNTH_FEEDBACK_DIV_N, {2'h0, n});
    check(config_out.first_div_code, c1);
    check(config_out.second_div_code, c2);
    check(config_out.third_div_ratio, n);
    synth_reset_bit = 1'b0;
    measure(cycles, sp_gap, fb_gap);
    check(sp_gap, 2 * r1 * r2);
    check(fb_gap, 2 * r1 * r2 * n);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    req = '0;
    synth_enable = 1'b1;
    synth_reset_bit = 1'b1;
    osc_pulse = 1'b0;
    err_count = 0;
    check_count = 0;
    cycle_count = 0;
    reg_addr = '{`OFS_REF_OUTPUT_CONTROL, `OFS_SYNTH_FEEDBACK_DIV_PV,
                 `OFS_SYNTH_FEEDBACK_DIV_N, `OFS_OSCILLATOR_BIAS_CONTROL,
                 `OFS_LANE_PREEMPHASIS_CONTROL};
    reg_rst = '{8'h01, 8'h00, 8'h20, 8'h4F, 8'h00};
    reg_mask = '{8'h01, 8'h0F, 8'h3F, 8'h7F, 8'h0F};
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    // reference output runs with no write at all
    check(synth_reference_output, 1'b1);
    check(config_out.third_div_ratio, 6'h20);
    // unmapped writes leave the bank alone
    write_reg(8'h40, 8'hFF);
    write_reg(8'h3B, 8'hFF);
    write_reg(8'h49, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      read_reg(reg_addr[i], rd);
      check(rd, reg_rst[i]);
    end
    read_reg(8'h40, rd);
    check(rd, 8'h00);
    // reserved bits read back as zero
    for (int i = 0; i < 5; i++) begin
      write_reg(reg_addr[i], 8'hFF);
      read_reg(reg_addr[i], rd);
      check(rd, reg_mask[i]);
    end
    // reference output gate, all four combinations
    for (int i = 0; i < 4; i++) begin
      write_reg(`OFS_REF_OUTPUT_CONTROL, {7'h0, i[1]});
      synth_enable = i[0];
      repeat (2) @(negedge clk);
      check(synth_reference_output, i[1] & i[0]);
      check(config_out.ref_out_enable, i[1]);
    end
    // one pre-emphasis value on every lane
    for (int v = 0; v < 16; v++) begin
      write_reg(`OFS_LANE_PREEMPHASIS_CONTROL, {4'h0, v[3:0]});
      for (int l = 0; l < 8; l++) begin
        check(lane_preemphasis[l], v[3:0]);
      end
      check(config_out.lane_preemphasis, v[3:0]);
    end
    // recommended bias before the synthesizer runs
    write_reg(`OFS_OSCILLATOR_BIAS_CONTROL, 8'h4A);
    check(config_out.oscillator_bias_level, 7'h4A);
    // every ratio code of the first and second divider
    for (int a = 0; a < 3; a++) begin
      for (int b = 0; b < 3; b++) begin
        run_div(a[1:0], b[1:0], 6'h03, 5 - a, 1 << b, 420);
      end
    end
    run_div(2'h0, 2'h0, 6'h3F, 5, 1, 2000);
    run_div(2'h2, 2'h0, 6'h01, 3, 1, 60);
    run_div(2'h3, 2'h0, 6'h03, 0, 1, 200);
    give_verdict();
  end
endmodule
